// ===== cod_pkg.sv
// Constants for the clock output and divider configuration bank.
// Assumes a byte-wide register map reached over a 4-wire serial port.
//
// What this block does
// - Swing code 00..11 selects 250, 500, 750 or 1000 mV; default 00.
// - Power-down set: output off, format, enable and swing ignored.
// - Format bit 0 selects low-voltage differential, 1 emitter-coupled.
// - Enable 0 holds the output static low; 1 drives it normally.
// - Loop feedback divide is 12 bits over two registers, default 3072.
// - Loop input pre-divide is 12 bits, default 3072.
// - Second feedback divider power-down bit 1 disables that divider.
// - Doubler bit 1 doubles the bypass mux output, pre-divider ignored.
package cod_pkg;
    localparam int NUM_REGS = 19;
    localparam int NUM_REFS = 8;
    // Serial frame: read flag, 7 address bits, 8 data bits, MSB first
    localparam logic [4:0] FRAME_HDR_LAST = 5'h07;
    localparam logic [4:0] FRAME_LAST = 5'h0f;
    // Register offsets
    localparam logic [6:0] VCXO_FB_DIV_HIGH_AND_WINDOW = 7'h00;
    localparam logic [6:0] VCXO_FB_DIV_LOW = 7'h01;
    localparam logic [6:0] SYNTH_FB_DIV_LOW = 7'h02;
    localparam logic [6:0] SYNTH_FB_DIV_HIGH_BYPASS = 7'h03;
    localparam logic [6:0] VCXO_PREDIV_HIGH_AND_WINDOW = 7'h04;
    localparam logic [6:0] VCXO_PREDIV_LOW = 7'h05;
    localparam logic [6:0] SYNTH_MULT_DIV_HIGH = 7'h08;
    localparam logic [6:0] SYNTH_MULT_DIV_LOW = 7'h09;
    localparam logic [6:0] SYNTH_INPUT_CONTROL = 7'h0c;
    localparam logic [6:0] LOCK_REPORT_AND_MISC = 7'h1f;
    localparam logic [6:0] REF_OUTPUT_ENABLES = 7'h76;
    // Per-output state registers, one per reference output
    localparam logic [6:0] REF_STATE_OFS [NUM_REFS] = '{7'h2c, 7'h2d, 7'h2e,
        7'h3c, 7'h3d, 7'h4c, 7'h4d, 7'h5c};
    // Bank table: offset, writable-bit mask, reset value
    localparam logic [6:0] REG_OFS [NUM_REGS] = '{
        VCXO_FB_DIV_HIGH_AND_WINDOW, VCXO_FB_DIV_LOW, SYNTH_FB_DIV_LOW,
        SYNTH_FB_DIV_HIGH_BYPASS, VCXO_PREDIV_HIGH_AND_WINDOW,
        VCXO_PREDIV_LOW, SYNTH_MULT_DIV_HIGH, SYNTH_MULT_DIV_LOW,
        SYNTH_INPUT_CONTROL, LOCK_REPORT_AND_MISC,
        7'h2c, 7'h2d, 7'h2e, 7'h3c, 7'h3d, 7'h4c, 7'h4d, 7'h5c,
        REF_OUTPUT_ENABLES};
    localparam logic [7:0] REG_MASK [NUM_REGS] = '{
        8'hff, 8'hff, 8'hff, 8'h81, 8'hef, 8'hff, 8'h01, 8'hff, 8'hff,
        8'hff, 8'hbc, 8'hbc, 8'hbc, 8'hbc, 8'hbc, 8'hbc, 8'hbc, 8'hbc,
        8'hff};
    localparam logic [7:0] REG_RESET [NUM_REGS] = '{
        8'hac, 8'h00, 8'h1e, 8'h00, 8'hac, 8'h00, 8'h00, 8'h1e, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00};
    // Indices into the bank table
    localparam int IDX_FBH = 0;
    localparam int IDX_FBL = 1;
    localparam int IDX_S2L = 2;
    localparam int IDX_S2H = 3;
    localparam int IDX_PVH = 4;
    localparam int IDX_PVL = 5;
    localparam int IDX_MFH = 6;
    localparam int IDX_MFL = 7;
    localparam int IDX_SIC = 8;
    localparam int IDX_LRM = 9;
    localparam int IDX_REF0 = 10;
    localparam int IDX_EN = 18;
    // Field positions in the per-output state register
    localparam int REF_PD_BIT = 7;
    localparam int REF_BIAS_BIT = 5;
    localparam int REF_FMT_BIT = 4;
    localparam int REF_SWING_LSB = 2;
    // Field positions in the divider registers
    localparam int WIN_LSB = 5;
    localparam int S2_OFF_BIT = 4;
    localparam int DBL_BIT = 7;
    localparam int SRC_BIT = 6;
    localparam int MASK_LOLV_BIT = 7;
    // Output swing in mV: (code + 1) * step
    localparam logic [9:0] SWING_STEP_MV = 10'h0fa;
    typedef enum logic [1:0] {
        COD_IDLE = 2'b00,
        COD_HDR = 2'b01,
        COD_DATA = 2'b10
    } cod_state_t;
endpackage

// ===== cod_sync.sv
// Two-flop synchroniser for a group of pin inputs.
// Assumes the inputs are asynchronous to clk.
`timescale 1ns/10ps
`default_nettype none
module cod_sync #(
    parameter int WIDTH = 3
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] asyncIn,
    output var logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_d;

    // First stage feeds only the second stage
    always_comb
    begin
        meta_d = asyncIn;
        sync_d = meta_q;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta_q <= '0;
            syncOut <= '0;
        end
        else
        begin
            meta_q <= meta_d;
            syncOut <= sync_d;
        end
    end
endmodule
`default_nettype wire

// ===== cod_regs.sv
// Configuration bank of reference output state and PLL divider settings.
// Assumes a host on the serial port; serial clock well below clk / 4.
`timescale 1ns/10ps
`default_nettype none
module cod_regs (
    input wire logic clk,
    input wire logic rst,
    input wire logic serialClk,
    input wire logic selectN,
    input wire logic serialIn,
    output var logic serialOut,
    output var logic serialOutEn,
    output var logic [cod_pkg::NUM_REFS-1:0] refPowerOff,
    output var logic [cod_pkg::NUM_REFS-1:0] refFormatEcl,
    output var logic [cod_pkg::NUM_REFS-1:0] refDriveEn,
    output var logic [cod_pkg::NUM_REFS-1:0] refBiasOn,
    output var logic [cod_pkg::NUM_REFS*10-1:0] refSwingMv,
    output var logic [11:0] vcxoLoopFbDivider,
    output var logic [11:0] vcxoLoopPrediv,
    output var logic [2:0] lockWindowFbPhase,
    output var logic [2:0] lockWindowRefPhase,
    output var logic [8:0] secondFbDivider,
    output var logic secondFbDividerOff,
    output var logic [8:0] synthMultDivider,
    output var logic [5:0] synthPrediv,
    output var logic doublerSelect,
    output var logic synthBypassSelect,
    output var logic synthFbBypass,
    output var logic maskVcxoUnlockReport,
    output var logic [6:0] miscControl
);
    import cod_pkg::*;

    logic [2:0] pinSync;
    logic sclkS;
    logic selNS;
    logic sdiS;
    logic sclkPrev_q;
    logic sclkPrev_d;
    cod_state_t state_q;
    cod_state_t state_d;
    logic [4:0] bitCnt_q;
    logic [4:0] bitCnt_d;
    logic [7:0] shiftIn_q;
    logic [7:0] shiftIn_d;
    logic [7:0] shiftOut_q;
    logic [7:0] shiftOut_d;
    logic [6:0] addr_q;
    logic [6:0] addr_d;
    logic isRead_q;
    logic isRead_d;
    logic sdo_d;
    logic sdoEn_d;
    logic wrStrobe;
    logic [7:0] readData;
    logic [7:0] bank_q [NUM_REGS];
    logic [7:0] bank_d [NUM_REGS];
    logic riseEdge;
    logic fallEdge;

    // Pins cross into clk before anything looks at them
    cod_sync #(.WIDTH(3)) pinSyncInst (
        .clk(clk),
        .rst(rst),
        .asyncIn({serialClk, selectN, serialIn}),
        .syncOut(pinSync)
    );
    assign sclkS = pinSync[2];
    assign selNS = pinSync[1];
    assign sdiS = pinSync[0];
    assign riseEdge = sclkS & ~sclkPrev_q;
    assign fallEdge = ~sclkS & sclkPrev_q;

    // Read mux; unmapped offsets and reserved bits read zero
    always_comb
    begin
        readData = 8'h00;
        for (int i = 0; i < NUM_REGS; i++)
        begin
            if (addr_d == REG_OFS[i])
            begin
                readData = bank_q[i] & REG_MASK[i];
            end
        end
    end

    // Serial frame sequencer, sampling on the serial clock rising edge
    always_comb
    begin
        state_d = state_q;
        bitCnt_d = bitCnt_q;
        shiftIn_d = shiftIn_q;
        shiftOut_d = shiftOut_q;
        addr_d = addr_q;
        isRead_d = isRead_q;
        sdo_d = serialOut;
        sdoEn_d = serialOutEn;
        wrStrobe = 1'b0;
        sclkPrev_d = sclkS;
        if (selNS)
        begin
            // Deselect aborts any partial frame; no write is made
            state_d = COD_IDLE;
            sdoEn_d = 1'b0;
            sdo_d = 1'b0;
        end
        else
        begin
            case (state_q)
                COD_IDLE:
                begin
                    bitCnt_d = 5'h00;
                    state_d = COD_HDR;
                end
                COD_HDR:
                begin
                    if (riseEdge)
                    begin
                        shiftIn_d = {shiftIn_q[6:0], sdiS};
                        bitCnt_d = bitCnt_q + 5'h01;
                        if (bitCnt_q == FRAME_HDR_LAST)
                        begin
                            isRead_d = shiftIn_q[6];
                            addr_d = {shiftIn_q[5:0], sdiS};
                            shiftOut_d = readData;
                            state_d = COD_DATA;
                        end
                    end
                end
                COD_DATA:
                begin
                    if (fallEdge && isRead_q)
                    begin
                        // Drive next read bit while clock is low
                        sdoEn_d = 1'b1;
                        sdo_d = shiftOut_q[7];
                        shiftOut_d = {shiftOut_q[6:0], 1'b0};
                    end
                    if (riseEdge)
                    begin
                        shiftIn_d = {shiftIn_q[6:0], sdiS};
                        bitCnt_d = bitCnt_q + 5'h01;
                        if (bitCnt_q == FRAME_LAST)
                        begin
                            wrStrobe = ~isRead_q;
                            state_d = COD_HDR;
                            bitCnt_d = 5'h00;
                        end
                    end
                end
                default:
                begin
                    state_d = COD_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_q <= COD_IDLE;
            bitCnt_q <= 5'h00;
            shiftIn_q <= 8'h00;
            shiftOut_q <= 8'h00;
            addr_q <= 7'h00;
            isRead_q <= 1'b0;
            serialOut <= 1'b0;
            serialOutEn <= 1'b0;
            sclkPrev_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            bitCnt_q <= bitCnt_d;
            shiftIn_q <= shiftIn_d;
            shiftOut_q <= shiftOut_d;
            addr_q <= addr_d;
            isRead_q <= isRead_d;
            serialOut <= sdo_d;
            serialOutEn <= sdoEn_d;
            sclkPrev_q <= sclkPrev_d;
        end
    end

    // Bank storage; only writable bits take the written byte
    generate
        for (genvar g = 0; g < NUM_REGS; g++)
        begin : gBank
            always_comb
            begin
                bank_d[g] = bank_q[g];
                if (wrStrobe && addr_q == REG_OFS[g])
                begin
                    bank_d[g] = {shiftIn_q[6:0], sdiS} & REG_MASK[g];
                end
            end

            always_ff @(posedge clk)
            begin
                if (rst)
                begin
                    bank_q[g] <= REG_RESET[g];
                end
                else
                begin
                    bank_q[g] <= bank_d[g];
                end
            end
        end
    endgenerate

    // Effective per-output state; power-down masks every other setting
    generate
        for (genvar r = 0; r < NUM_REFS; r++)
        begin : gRef
            logic [7:0] st;
            logic on;
            logic [1:0] code;
            logic [9:0] mv;
            assign st = bank_q[IDX_REF0+r];
            assign on = ~st[REF_PD_BIT];
            assign code = st[REF_SWING_LSB+1:REF_SWING_LSB];
            // Same swing table for both formats
            assign mv = SWING_STEP_MV * ({8'h00, code} + 10'h001);

            always_ff @(posedge clk)
            begin
                if (rst)
                begin
                    refPowerOff[r] <= 1'b0;
                    refFormatEcl[r] <= 1'b0;
                    refDriveEn[r] <= 1'b0;
                    refBiasOn[r] <= 1'b0;
                    refSwingMv[r*10+:10] <= 10'h000;
                end
                else
                begin
                    refPowerOff[r] <= ~on;
                    refFormatEcl[r] <= on & st[REF_FMT_BIT];
                    // Disabled output sits static low
                    refDriveEn[r] <= on & bank_q[IDX_EN][7-r];
                    refBiasOn[r] <= on & st[REF_BIAS_BIT];
                    refSwingMv[r*10+:10] <= on ? mv : 10'h000;
                end
            end
        end
    endgenerate

    // Divider fields registered out of the bank
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            vcxoLoopFbDivider <= 12'h000;
            vcxoLoopPrediv <= 12'h000;
            lockWindowFbPhase <= 3'h0;
            lockWindowRefPhase <= 3'h0;
            secondFbDivider <= 9'h000;
            secondFbDividerOff <= 1'b0;
            synthMultDivider <= 9'h000;
            synthPrediv <= 6'h00;
            doublerSelect <= 1'b0;
            synthBypassSelect <= 1'b0;
            synthFbBypass <= 1'b0;
            maskVcxoUnlockReport <= 1'b0;
            miscControl <= 7'h00;
        end
        else
        begin
            vcxoLoopFbDivider <= {bank_q[IDX_FBH][3:0],
                bank_q[IDX_FBL]};
            vcxoLoopPrediv <= {bank_q[IDX_PVH][3:0],
                bank_q[IDX_PVL]};
            lockWindowFbPhase <= bank_q[IDX_FBH][WIN_LSB+:3];
            lockWindowRefPhase <= bank_q[IDX_PVH][WIN_LSB+:3];
            secondFbDivider <= {bank_q[IDX_S2H][7], bank_q[IDX_S2L]};
            secondFbDividerOff <= bank_q[IDX_FBH][S2_OFF_BIT];
            synthMultDivider <= {bank_q[IDX_MFH][0], bank_q[IDX_MFL]};
            // Pre-divider is dropped while the doubler feeds the synth
            synthPrediv <= bank_q[IDX_SIC][DBL_BIT] ? 6'h00
                : bank_q[IDX_SIC][5:0];
            doublerSelect <= bank_q[IDX_SIC][DBL_BIT];
            synthBypassSelect <= bank_q[IDX_SIC][SRC_BIT];
            synthFbBypass <= bank_q[IDX_S2H][0];
            maskVcxoUnlockReport <= bank_q[IDX_LRM][MASK_LOLV_BIT];
            miscControl <= bank_q[IDX_LRM][6:0];
        end
    end
endmodule
`default_nettype wire

// ===== cod_regs_chk.sv
// Port checker for the divider and output-state configuration bank.
// Assumes it is bound to cod_regs and shares its clock and reset.
`timescale 1ns/10ps
`default_nettype none
module cod_regs_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic selectN,
    input wire logic [cod_pkg::NUM_REFS-1:0] refPowerOff,
    input wire logic [cod_pkg::NUM_REFS-1:0] refFormatEcl,
    input wire logic [cod_pkg::NUM_REFS-1:0] refDriveEn,
    input wire logic [cod_pkg::NUM_REFS*10-1:0] refSwingMv,
    input wire logic [11:0] vcxoLoopFbDivider,
    input wire logic [11:0] vcxoLoopPrediv,
    input wire logic secondFbDividerOff,
    input wire logic [5:0] synthPrediv,
    input wire logic doublerSelect
);
    import cod_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // No frame for eight cycles: nothing may be written
    sequence s_quiet;
        selectN [*8];
    endsequence
    // Derived outputs settle one edge after reset; this waits two edges
    sequence s_settled;
        !$past(rst) && !$past(rst, 2);
    endsequence
    a_pd_format: assert property (
        (refPowerOff & refFormatEcl) == 8'h00)
        else $error("format active on a powered-down output");
    a_pd_enable: assert property (
        (refPowerOff & refDriveEn) == 8'h00)
        else $error("drive active on a powered-down output");
    a_pd_swing: assert property (
        refPowerOff[0] |-> refSwingMv[9:0] == 10'h000)
        else $error("swing present on a powered-down output");
    a_swing_values: assert property (
        s_settled ##0 !refPowerOff[0] |->
        refSwingMv[9:0] inside {10'h0fa, 10'h1f4, 10'h2ee, 10'h3e8})
        else $error("swing outside the four legal levels");
    a_doubler_prediv: assert property (
        doublerSelect |-> synthPrediv == 6'h00)
        else $error("pre-divider live while doubler selected");
    a_fb_hold: assert property (
        s_quiet |=> $stable(vcxoLoopFbDivider))
        else $error("feedback divider changed with no frame");
    a_prediv_hold: assert property (
        s_quiet |=> $stable(vcxoLoopPrediv))
        else $error("pre-divider changed with no frame");
    a_s2off_hold: assert property (
        s_quiet |=> $stable(secondFbDividerOff))
        else $error("second divider power state changed with no frame");
    a_format_hold: assert property (
        s_quiet |=> $stable(refFormatEcl))
        else $error("output format changed with no frame");
endmodule
bind cod_regs cod_regs_chk i_cod_regs_chk (.clk(clk), .rst(rst),
    .selectN(selectN), .refPowerOff(refPowerOff),
    .refFormatEcl(refFormatEcl), .refDriveEn(refDriveEn),
    .refSwingMv(refSwingMv), .vcxoLoopFbDivider(vcxoLoopFbDivider),
    .vcxoLoopPrediv(vcxoLoopPrediv), .secondFbDividerOff(secondFbDividerOff),
    .synthPrediv(synthPrediv), .doublerSelect(doublerSelect));
`default_nettype wire

// ===== cod_host.sv
// Host controller model on the serial configuration port.
// Assumes clk is the bank clock; serial phases last five clk each.
`timescale 1ns/10ps
`default_nettype none
module cod_host (
    input wire logic clk,
    input wire logic serialOut,
    input wire logic serialOutEn,
    output var logic serialClk,
    output var logic selectN,
    output var logic serialIn,
    output var logic rdDone,
    output var logic [7:0] rdData
);
    // Serial clock idles low outside frames
    initial
    begin
        serialClk = 1'b0;
        selectN = 1'b1;
        serialIn = 1'b0;
        rdDone = 1'b0;
        rdData = 8'h00;
    end
    // Lock window code from the feedback divide, for divides of 32 and up
    function automatic logic [2:0] win(input logic [11:0] dv);
        int b;
        b = 0;
        for (int i = 0; i < 12; i++)
            if (dv[i])
                b = i;
        return (b < 5) ? 3'h2 : ((b > 10) ? 3'h7 : 3'(b - 3));
    endfunction
    // One frame MSB first; fewer than 16 bits aborts it
    task automatic frame(input logic [15:0] w, input int nb);
        logic [7:0] q;
        q = 8'h00;
        @(posedge clk) selectN <= 1'b0;
        for (int i = 0; i < nb; i++)
        begin
            serialClk <= 1'b0;
            serialIn <= w[15-i];
            repeat (5) @(posedge clk);
            // Undriven line shows the inverse, so a missing enable is seen
            q = {q[6:0], serialOutEn ? serialOut : ~serialOut};
            serialClk <= 1'b1;
            repeat (5) @(posedge clk);
        end
        serialClk <= 1'b0;
        serialIn <= ~serialIn; // Released line shows no stale bit
        repeat (5) @(posedge clk);
        selectN <= 1'b1;
        @(posedge clk) rdDone <= w[15] && nb == 16;
        rdData <= q;
        @(posedge clk) rdDone <= 1'b0;
        repeat (6) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// ===== test_clock_output_and_divider_regs.sv
// Self-checking bench of the configuration bank through its serial port.
// Assumes the host model cod_host and the bound port checker.
`timescale 1ns/10ps
`default_nettype none
module test_clock_output_and_divider_regs;
    import cod_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic serialClk, selectN, serialIn, serialOut, serialOutEn, rdDone;
    logic [7:0] rdData, refPowerOff, refFormatEcl, refDriveEn, refBiasOn;
    logic [79:0] refSwingMv;
    logic [11:0] vcxoLoopFbDivider, vcxoLoopPrediv, dv;
    logic [2:0] lockWindowFbPhase, lockWindowRefPhase;
    logic [8:0] secondFbDivider, synthMultDivider;
    logic [5:0] synthPrediv;
    logic [6:0] miscControl;
    logic doublerSelect, synthBypassSelect, synthFbBypass;
    logic maskVcxoUnlockReport, secondFbDividerOff;
    logic [7:0] sh [NUM_REGS];
    logic [7:0] expQ [$];
    logic [31:0] rs = 32'd64059;
    int mismatches = 0;
    int n_compared = 0;
    int cycles = 0;
    always #5 clk = ~clk;
    cod_regs i_cod_regs (.clk, .rst, .serialClk, .selectN, .serialIn,
        .serialOut, .serialOutEn, .refPowerOff, .refFormatEcl, .refDriveEn,
        .refBiasOn, .refSwingMv, .vcxoLoopFbDivider, .vcxoLoopPrediv,
        .lockWindowFbPhase, .lockWindowRefPhase, .secondFbDivider,
        .secondFbDividerOff, .synthMultDivider, .synthPrediv, .doublerSelect,
        .synthBypassSelect, .synthFbBypass, .maskVcxoUnlockReport, .miscControl);
    cod_host i_cod_host (.clk, .serialOut, .serialOutEn, .serialClk, .selectN,
        .serialIn, .rdDone, .rdData);
    function automatic logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction
    task automatic cmp(input string nm, input logic [15:0] e, logic [15:0] s);
        n_compared++;
        if (s !== e)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        i_cod_host.frame({1'b0, a, d}, 16);
    endtask
    // Expectation is queued before the frame goes out
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        expQ.push_back(e);
        i_cod_host.frame({1'b1, a, 8'(rnd())}, 16);
    endtask
    task automatic stop_test();
        $display("Compared %0d, mismatched %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Read results are matched against the oldest queued expectation
    always @(posedge clk)
        if (rdDone === 1'b1)
            cmp("read", expQ.size() ? expQ.pop_front() : 8'h5a,
                rdData);
    // Hang guard; all frames need about 11600 cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            mismatches++;
            stop_test();
        end
    end
    initial
    begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
        cmp("fbdiv", 16'd3072, vcxoLoopFbDivider);
        cmp("prediv", 16'd3072, vcxoLoopPrediv);
        cmp("window", 16'h2d, {lockWindowRefPhase,
            lockWindowFbPhase});
        cmp("doubler", 16'h0, doublerSelect);
        cmp("swing", 16'd250, refSwingMv[9:0]);
        cmp("state", 16'h0, {refFormatEcl, refDriveEn});
        cmp("power", 16'h0, refPowerOff);
        rd(7'h00, {3'b101, 1'b0, 4'hc});
        rd(7'h04, {3'b101, 1'b0, 4'hc});
        $display("reset test done");
        for (int i = 0; i < NUM_REGS; i++)
        begin
            sh[i] = 8'(rnd());
            wr(REG_OFS[i], sh[i]);
            rd(REG_OFS[i], sh[i] & REG_MASK[i]);
        end
        wr(7'h7f, 8'hff);
        rd(7'h7f, 8'h00);
        i_cod_host.frame({1'b0, VCXO_PREDIV_LOW, ~sh[IDX_PVL]}, 12);
        rd(VCXO_PREDIV_LOW, sh[IDX_PVL]);
        cmp("prediv", {sh[IDX_PVH][3:0], sh[IDX_PVL]},
            vcxoLoopPrediv);
        // Fields only reached through the bank, checked against stored bytes
        cmp("s2div", {sh[IDX_S2H][7], sh[IDX_S2L]},
            secondFbDivider);
        cmp("mfdiv", {sh[IDX_MFH][0], sh[IDX_MFL]},
            synthMultDivider);
        cmp("misc", {sh[IDX_SIC][SRC_BIT], sh[IDX_S2H][0], sh[IDX_LRM]},
            {synthBypassSelect, synthFbBypass, maskVcxoUnlockReport,
            miscControl});
        for (int r = 0; r < NUM_REFS; r++)
            cmp("bias", !sh[IDX_REF0+r][REF_PD_BIT]
                && sh[IDX_REF0+r][REF_BIAS_BIT], refBiasOn[r]);
        $display("access test done");
        for (int k = 0; k < 2; k++)
        begin
            dv = 12'(rnd()) | 12'h020;
            wr(7'h00, {i_cod_host.win(dv), k[0], dv[11:8]});
            wr(7'h01, dv[7:0]);
            cmp("fbdiv", dv, vcxoLoopFbDivider);
            cmp("s2off", k[0], secondFbDividerOff);
            cmp("window", i_cod_host.win(dv), lockWindowFbPhase);
            wr(7'h0c, {k[0], 1'b0, 6'h15});
            cmp("doubler", k[0], doublerSelect);
            cmp("prediv", k[0] ? 6'h00 : 6'h15, synthPrediv);
        end
        $display("divider test done");
        for (int r = 0; r < 8; r++)
            wr(REF_STATE_OFS[r], {3'b000, r[2], r[1:0], 2'b00});
        wr(REF_OUTPUT_ENABLES, 8'ha5);
        for (int r = 0; r < 8; r++)
        begin
            cmp("swing", (r % 4 + 1) * 250, refSwingMv[r*10+:10]);
            cmp("format", r[2], refFormatEcl[r]);
            cmp("enable", 8'ha5 >> (7 - r) & 1, refDriveEn[r]);
            wr(REF_STATE_OFS[r], 8'hbc);
            cmp("off", 16'h0, {refSwingMv[r*10+:10], refFormatEcl[r],
                refDriveEn[r], ~refPowerOff[r]});
        end
        $display("output test done");
        repeat (4) @(posedge clk);
        stop_test();
    end
endmodule
`default_nettype wire
